/* File: logic/ubp_defines.vh */
// Overview of operation
// [RQ1] Only port bits 7..4 take part in pin-change detection.
// [RQ2] Software can enable weak pull-ups on input pins.
// [RQ3] Low-voltage programming disables change detection and pull-up on bit 4.
// [RQ4] A configuration input, not a register bit, selects bit 4 role.
// [RQ5] Reading the data register returns the pin levels.
// [RQ6] Writes load the latch; only output-direction pins drive it.
// [RQ7] Bit set/clear reads pins, changes one bit, writes all back.
// [RQ8] Such writes overwrite latches of input pins with sensed levels.
// [RQ9] Data register at two mirrored offsets; latch untouched by reset.
// [RQ10] Direction register mirrored at two offsets, resets to all ones.
// [RQ11] Bits 1 and 2 serve the serial port when it claims them.
// [RQ12] Direction one floats the pin; zero drives the latch value.
// [RQ13] Clearing the pull-up control bit enables pull-ups; outputs never pulled.
// [RQ14] Inputs 7..4 compared with last-read value; mismatches ORed into flag.
// [RQ15] A standing mismatch keeps setting the flag until the port is accessed.
// [RQ16] Change flag is sticky until cleared and raises a wake request.
`ifndef UBP_DEFINES_VH
`define UBP_DEFINES_VH

// ==========================================================
// Register word offsets (byte address = 4 * index)
`define UBP_IDX_DATA      10'h006
`define UBP_IDX_DATA_MIR  10'h106
`define UBP_IDX_OPTION    10'h081
`define UBP_IDX_OPTION_MIR 10'h181
`define UBP_IDX_DIR       10'h086
`define UBP_IDX_DIR_MIR   10'h186
`define UBP_IDX_BITOP     10'h200
`define UBP_IDX_STATUS    10'h201
`define UBP_IDX_MASK      10'h202

// ==========================================================
// Field positions and reset values
`define UBP_OPT_PULLUP_N  7
`define UBP_BITOP_SET     3
`define UBP_DIR_RESET     8'hff
`define UBP_OPT_RESET     8'hff
`define UBP_MASK_RESET    1'b0
`define UBP_ST_CHANGE     0
`define UBP_CHANGE_BITS   8'hf0
`define UBP_LAST_RESET    8'h00
`define UBP_PIN_RESET     8'h00
`define UBP_OE_N_RESET    8'hff
`define UBP_PULL_RESET    8'h00

`endif

/* File: logic/ubp_sync2.v */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for pin levels
module ubp_sync2 #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // Data
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);

    reg [W-1:0] meta_reg;

    // First stage feeds only the second
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= {W{1'b0}};
            q_o      <= {W{1'b0}};
        end
        else
        begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end

endmodule // ubp_sync2

`default_nettype wire

/* File: logic/ubp_port.v */
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ubp_defines.vh"

// ==========================================================
// Eight-bit bidirectional port with pin-change interrupt
module ubp_port (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [11:0] wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Pins, four signals each; oe low means driving
    input  wire [7:0]  pin_i,
    output reg  [7:0]  pin_o,
    output reg  [7:0]  pin_oe_n_o,
    output reg  [7:0]  pullup_on_o,
    // Configuration and serial port sharing
    input  wire        low_voltage_prog_cfg_i,
    input  wire        ser_claim_i,
    input  wire        sync_data_io_out_i,
    input  wire        sync_data_io_drive_i,
    input  wire        sync_clock_io_out_i,
    input  wire        sync_clock_io_drive_i,
    output reg         sync_data_io_in_o,
    output reg         sync_clock_io_in_o,
    output reg         low_voltage_prog_input_o,
    // Interrupt and wake
    output reg         irq_o,
    output reg         wake_o
);

    // ==========================================================
    // State
    reg  [7:0] upper_port_data_reg;   // output latch, no reset
    reg  [7:0] upper_port_direction_reg;
    reg  [7:0] option_config_reg;
    reg  [7:0] last_read_reg;
    reg        pin_change_flag_reg;
    reg        irq_mask_reg;
    wire [7:0] pin_s;
    reg  [7:0] dir_eff;
    reg  [7:0] drv_val;
    reg  [7:0] mismatch;
    reg  [7:0] latch_next;
    reg  [7:0] pull_next;
    reg  [31:0] rd_next;
    wire [9:0] idx;
    wire       req;
    wire       wr;
    wire       hit_data;
    wire       hit_dir;
    wire       hit_opt;
    wire       hit_bitop;
    wire       hit_st;
    wire       hit_mask;
    wire       change_ev;
    wire       pullup_n;
    wire       clr_flag;

    // Pins cross into the clock domain first
    ubp_sync2 #(
        .W (8)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (pin_i),
        .q_o   (pin_s)
    );

    // ==========================================================
    // Bus decode; request taken while no ack is out
    assign idx       = wb_adr_i[11:2];
    assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr        = req & wb_we_i & wb_sel_i[0];
    assign hit_data  = (idx == `UBP_IDX_DATA) || (idx == `UBP_IDX_DATA_MIR);   // [RQ9]
    assign hit_dir   = (idx == `UBP_IDX_DIR) || (idx == `UBP_IDX_DIR_MIR);     // [RQ10]
    assign hit_opt   = (idx == `UBP_IDX_OPTION) || (idx == `UBP_IDX_OPTION_MIR);
    assign hit_bitop = (idx == `UBP_IDX_BITOP);
    assign hit_st    = (idx == `UBP_IDX_STATUS);
    assign hit_mask  = (idx == `UBP_IDX_MASK);
    assign pullup_n  = option_config_reg[`UBP_OPT_PULLUP_N];

    // ==========================================================
    // Pin direction, drive and change compare
    // Effective direction and drive, serial port overriding bits 1 and 2
    always @*
    begin
        dir_eff = upper_port_direction_reg;
        drv_val = upper_port_data_reg;   // [RQ12]
        if (ser_claim_i)
        begin
            dir_eff[1] = ~sync_data_io_drive_i;   // [RQ11]
            drv_val[1] = sync_data_io_out_i;
            dir_eff[2] = ~sync_clock_io_drive_i;  // [RQ11]
            drv_val[2] = sync_clock_io_out_i;
        end
    end

    // Change detection only on input pins 7..4, bit 4 lost to programming
    always @*
    begin
        mismatch = (pin_s ^ last_read_reg) & dir_eff & `UBP_CHANGE_BITS;   // [RQ1] [RQ14]
        if (low_voltage_prog_cfg_i)
            mismatch[4] = 1'b0;   // [RQ3]
    end
    assign change_ev = |mismatch;   // [RQ15]

    // Latch update: plain write, or bit op on sensed pin levels
    always @*
    begin
        latch_next = upper_port_data_reg;
        if (wr && hit_data)
            latch_next = wb_dat_i[7:0];   // [RQ6]
        else if (wr && hit_bitop)
        begin
            latch_next = pin_s;   // [RQ7] [RQ8] inputs overwrite their latches
            latch_next[wb_dat_i[2:0]] = wb_dat_i[`UBP_BITOP_SET];
        end
    end

    // Output latch holds through reset
    // Unknown until first written; load it before turning any pin to output
    always @(posedge clk_i)
    begin
        upper_port_data_reg <= latch_next;   // [RQ9]
    end

    // ==========================================================
    // Bus answer and read data
    // Flag clear: a one written to the status word
    assign clr_flag = wr && hit_st && wb_dat_i[`UBP_ST_CHANGE];

    // One-cycle ack; a held request is not taken twice
    always @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    // Read mux; unmapped words read as zero
    always @*
    begin
        rd_next = 32'h0000_0000;
        if (hit_data)
            rd_next = {24'h00_0000, pin_s};   // [RQ5]
        else if (hit_dir)
            rd_next = {24'h00_0000, upper_port_direction_reg};
        else if (hit_opt)
            rd_next = {24'h00_0000, option_config_reg};
        else if (hit_st)
            rd_next = {31'h0000_0000, pin_change_flag_reg};
        else if (hit_mask)
            rd_next = {31'h0000_0000, irq_mask_reg};
    end

    // Read data stands for the ack cycle only, zero otherwise
    always @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_we_i)
            wb_dat_o <= rd_next;
        else
            wb_dat_o <= 32'h0000_0000;
    end

    // ==========================================================
    // Configuration registers
    // Direction: every pin an input out of any reset
    always @(posedge clk_i)
    begin
        if (rst_i)
            upper_port_direction_reg <= `UBP_DIR_RESET;   // [RQ10]
        else if (wr && hit_dir)
            upper_port_direction_reg <= wb_dat_i[7:0];
    end

    // Option: only the pull-up control bit is used here
    always @(posedge clk_i)
    begin
        if (rst_i)
            option_config_reg <= `UBP_OPT_RESET;
        else if (wr && hit_opt)
            option_config_reg <= wb_dat_i[7:0];   // [RQ13]
    end

    // Interrupt mask, off out of reset
    always @(posedge clk_i)
    begin
        if (rst_i)
            irq_mask_reg <= `UBP_MASK_RESET;
        else if (wr && hit_mask)
            irq_mask_reg <= wb_dat_i[`UBP_ST_CHANGE];
    end

    // ==========================================================
    // Change detection state
    // Any data or bit-op access relatches the pins, ending the mismatch
    always @(posedge clk_i)
    begin
        if (rst_i)
            last_read_reg <= `UBP_LAST_RESET;
        else if (req && (hit_data || hit_bitop))
            last_read_reg <= pin_s;   // [RQ15]
    end

    // Sticky flag; set wins over a same-cycle clear,
    // so a standing mismatch cannot be cleared away
    always @(posedge clk_i)
    begin
        if (rst_i)
            pin_change_flag_reg <= 1'b0;
        else if (change_ev)
            pin_change_flag_reg <= 1'b1;   // [RQ16]
        else if (clr_flag)
            pin_change_flag_reg <= 1'b0;
    end

    // ==========================================================
    // Registered pin, pull-up and interrupt outputs
    // Pull-ups only on inputs, all gated by one active-low bit
    always @*
    begin
        pull_next = {8{~pullup_n}} & dir_eff;   // [RQ2] [RQ13]
        if (low_voltage_prog_cfg_i)
            pull_next[4] = 1'b0;   // [RQ3]
    end

    // Drive value and enable; floating out of reset
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_o      <= `UBP_PIN_RESET;
            pin_oe_n_o <= `UBP_OE_N_RESET;
        end
        else
        begin
            pin_o      <= drv_val;
            pin_oe_n_o <= dir_eff;   // [RQ12]
        end
    end

    // Pull-ups off in reset, so nothing is pulled before it is configured
    always @(posedge clk_i)
    begin
        if (rst_i)
            pullup_on_o <= `UBP_PULL_RESET;
        else
            pullup_on_o <= pull_next;   // [RQ2] [RQ13]
    end

    // Synced pin levels back to the serial port
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_data_io_in_o  <= 1'b0;
            sync_clock_io_in_o <= 1'b0;
        end
        else
        begin
            sync_data_io_in_o  <= pin_s[1];   // [RQ11]
            sync_clock_io_in_o <= pin_s[2];   // [RQ11]
        end
    end

    // Strap, not software, decides the bit 4 role
    always @(posedge clk_i)
    begin
        if (rst_i)
            low_voltage_prog_input_o <= 1'b0;
        else
            low_voltage_prog_input_o <= low_voltage_prog_cfg_i & pin_s[4];   // [RQ4]
    end

    // Level interrupt and wake request; wake ignores the mask
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            irq_o  <= pin_change_flag_reg & irq_mask_reg;
            wake_o <= pin_change_flag_reg;   // [RQ16]
        end
    end

endmodule // ubp_port

`default_nettype wire

/* File: testbench/ubp_board.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Board around the pins: device drive, board drive, pull-up
module ubp_board (
    input wire logic       clk_i,
    input wire logic [7:0] pin_o, pin_oe_n_o, pullup_on_o, ext_val_i, ext_en_i,
    output logic     [7:0] pin_i
);
    logic [7:0] drift_reg = 8'h5a;
    // Undriven, unpulled lines wander so a stale level never passes for a real one
    always @(posedge clk_i) drift_reg <= ~drift_reg;
    // Device driver wins over the board; pull-up only when nothing drives
    always_comb
        for (int i = 0; i < 8; i++)
            pin_i[i] = !pin_oe_n_o[i] ? pin_o[i] : ext_en_i[i] ? ext_val_i[i] : pullup_on_o[i] ? 1'b1 : drift_reg[i];
endmodule // ubp_board
`default_nettype wire

/* File: testbench/ubp_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus and pin checks on the port's boundary
module ubp_port_monitor (
    input wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, wake_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [7:0]  pin_o, pin_oe_n_o, pullup_on_o,
    input wire logic        low_voltage_prog_cfg_i, ser_claim_i, sync_data_io_out_i, sync_data_io_drive_i,
    input wire logic        sync_clock_io_out_i, sync_clock_io_drive_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_write_dat_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000)
        else $error("write answered with nonzero data");
    a_no_pull_out: assert property ((pullup_on_o & ~pin_oe_n_o) == 8'h00)
        else $error("pull-up on a driven pin");
    a_prog_bit4: assert property (low_voltage_prog_cfg_i && $past(low_voltage_prog_cfg_i) |-> !pullup_on_o[4])
        else $error("bit 4 pull-up under programming mode");
    a_irq_flag: assert property (irq_o |-> wake_o) else $error("interrupt without flag");
    a_flag_sticky: assert property ($fell(wake_o) |-> $past(wb_we_i && wb_stb_i) || $past(wb_we_i && wb_stb_i, 2))
        else $error("flag dropped without a write");
    a_ser_data: assert property ($past(ser_claim_i) && $past(sync_data_io_drive_i) |->
        !pin_oe_n_o[1] && pin_o[1] == $past(sync_data_io_out_i)) else $error("serial data not on pin 1");
    a_ser_clock: assert property ($past(ser_claim_i) && $past(sync_clock_io_drive_i) |->
        !pin_oe_n_o[2] && pin_o[2] == $past(sync_clock_io_out_i)) else $error("serial clock not on pin 2");
    c_irq: cover property ($rose(irq_o));
    c_ser: cover property (ser_claim_i && sync_clock_io_drive_i);
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule // ubp_port_monitor
bind ubp_port ubp_port_monitor u_mon (.*);
`default_nettype wire

/* File: testbench/ubp_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ubp_defines.vh"
// ==========================================
// Port bench: registers, pins, change interrupt, serial sharing
module ubp_port_test;
    localparam [11:0] AD = {`UBP_IDX_DATA, 2'b00}, ADM = {`UBP_IDX_DATA_MIR, 2'b00}, AO = {`UBP_IDX_OPTION, 2'b00};
    localparam [11:0] AT = {`UBP_IDX_DIR, 2'b00}, ATM = {`UBP_IDX_DIR_MIR, 2'b00}, AB = {`UBP_IDX_BITOP, 2'b00};
    localparam [11:0] AS = {`UBP_IDX_STATUS, 2'b00}, AM = {`UBP_IDX_MASK, 2'b00};
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, low_voltage_prog_cfg_i = 0, ser_claim_i = 0;
    logic sync_data_io_out_i = 0, sync_data_io_drive_i = 0, sync_clock_io_out_i = 0, sync_clock_io_drive_i = 0;
    logic [3:0] wb_sel_i = 4'h1;
    logic [11:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
    logic wb_ack_o, sync_data_io_in_o, sync_clock_io_in_o, low_voltage_prog_input_o, irq_o, wake_o;
    logic [7:0] pin_i, pin_o, pin_oe_n_o, pullup_on_o, ev = 0, ee = 0, dir, lat, pv;
    integer err_count = 0, checks_done = 0, seed = 1, i;
    always #10 clk_i = ~clk_i;
    ubp_port u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_on_o(pullup_on_o),
        .low_voltage_prog_cfg_i(low_voltage_prog_cfg_i), .ser_claim_i(ser_claim_i),
        .sync_data_io_out_i(sync_data_io_out_i), .sync_data_io_drive_i(sync_data_io_drive_i),
        .sync_clock_io_out_i(sync_clock_io_out_i), .sync_clock_io_drive_i(sync_clock_io_drive_i),
        .sync_data_io_in_o(sync_data_io_in_o), .sync_clock_io_in_o(sync_clock_io_in_o),
        .low_voltage_prog_input_o(low_voltage_prog_input_o), .irq_o(irq_o), .wake_o(wake_o)
    );
    ubp_board u_brd (
        .clk_i(clk_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_on_o(pullup_on_o),
        .ext_val_i(ev), .ext_en_i(ee), .pin_i(pin_i)
    );
    // Expected pin levels: own drive on outputs, board level on inputs
    function automatic logic [7:0] exp_pins(input logic [7:0] l, input logic [7:0] d, input logic [7:0] e);
        return (l & ~d) | (e & d);
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One classic cycle; waits bounded, released only after ack is seen
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20)
        begin
            $display("FAIL wb ack expected 1 seen %b", wb_ack_o);
            err_count++;
            conclude();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 0; wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        wb(0, a, 0);
        chk(nm, e, rd);
    endtask
    // Covers the two-stage pin synchroniser plus the registered flag
    task automatic settle;
        repeat (6) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0; ee <= 8'hff;
        @(posedge clk_i);
        wb_sel_i <= 4'h0;
        wb(1, AT, 0);
        wb_sel_i <= 4'h1;
        rc("dir", AT, 32'h0000_00ff);
        rc("dir mirror", ATM, 32'h0000_00ff);
        rc("option", AO, 32'h0000_00ff);
        rc("mask", AM, 0);
        rc("unmapped", 12'hffc, 0);
        // Random latch, direction and board levels; data register through both mirrors
        for (i = 0; i < 8; i++)
        begin
            lat = 8'($random(seed)); dir = 8'($random(seed)); ev <= 8'($random(seed)); ee <= dir;
            wb(1, i[0] ? ADM : AD, {24'h0, lat});
            wb(1, AT, {24'h0, dir});
            settle;
            chk("oe", dir, pin_oe_n_o);
            chk("drive", lat & ~dir, pin_o & ~dir);
            pv = exp_pins(lat, dir, ev);
            chk("data in", pv[1], sync_data_io_in_o);
            chk("clock in", pv[2], sync_clock_io_in_o);
            rc("pins", i[0] ? AD : ADM, {24'h0, pv});
        end
        wb(1, AD, 0); ev <= 8'h01; ee <= 8'h01;
        wb(1, AT, 1);
        settle;
        wb(1, AB, 32'h0000_000d);
        ee <= 0;
        wb(1, AT, 0);
        settle;
        chk("bit set", 8'h21, pin_o);
        wb(1, AB, 32'h0000_0005);
        settle;
        chk("bit clear", 8'h01, pin_o);
        wb(1, AT, 32'h0000_00ff); wb(1, AO, 32'h0000_007f);
        settle;
        chk("pullups", 8'hff, pullup_on_o);
        rc("pulled pins", AD, 32'h0000_00ff);
        low_voltage_prog_cfg_i <= 1; ee <= 8'hff; ev <= 8'h10;
        settle;
        chk("prog pull", 8'hef, pullup_on_o);
        chk("prog in", 1, low_voltage_prog_input_o);
        wb(0, AD, 0); wb(1, AS, 1); wb(1, AM, 1);
        ev <= 8'h0f;
        settle;
        chk("low bits", 0, irq_o);
        ev <= 8'h8f;
        settle;
        chk("change", 1, irq_o);
        wb(1, AS, 1);
        settle;
        chk("mismatch", 1, wake_o);
        wb(1, AM, 0);
        chk("masked", 0, irq_o);
        wb(0, AD, 0); wb(1, AS, 1);
        settle;
        chk("cleared", 0, wake_o);
        ser_claim_i <= 1; sync_data_io_drive_i <= 1; sync_data_io_out_i <= 1; ev <= 8'h04;
        settle;
        chk("ser oe", 8'hfd, pin_oe_n_o);
        chk("ser in", 1, sync_clock_io_in_o);
        sync_clock_io_drive_i <= 1; ee <= 8'hf9;
        settle;
        chk("ser pins", 8'h02, pin_o & 8'h06);
        ser_claim_i <= 0; ee <= 0; rst_i <= 1;
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(1, AT, 0);
        settle;
        chk("latch kept", 8'h01, pin_o);
        conclude();
    end
endmodule // ubp_port_test
`default_nettype wire
